/* File: cmp_async_latch.sv */
// Purpose: clockless change catcher used while the cpu clock is stopped
// Assumes: cmp_async is the raw comparator output, arm is synchronous
// Notes: modeled with a flop per edge polarity; clear resets both
`timescale 1ns/1ps
module cmp_async_latch
(
  // raw comparator level
  input wire logic cmp_async,
  // arm and clear, active low clear
  input wire logic arm,
  input wire logic clr_n,
  // caught change
  output logic seen
);
  logic rise_q;
  logic fall_q;

  // each edge of the raw output clocks arm in; no cpu clock needed
  always_ff @(posedge cmp_async or negedge clr_n)
  begin
    if (!clr_n)
      rise_q <= 1'b0;
    else
      rise_q <= arm;
  end

  always_ff @(negedge cmp_async or negedge clr_n)
  begin
    if (!clr_n)
      fall_q <= 1'b0;
    else
      fall_q <= arm;
  end

  assign seen = rise_q | fall_q;
endmodule

/* File: cmp_irq_pkg.sv */
// Purpose: constants for the comparator event and wake logic
// Assumes: one cpu clock mclk at 250 MHz
// Notes: control register layout per comparator
// Operation
// - set a comparator's change flag on every output toggle; flag readable by polling
// - request interrupt only when flag, per-comparator enable and global enable set
// - comparators keep working and flagging in idle and power-down
// - enabled comparator change in reduced power raises interrupt and wakes cpu; cmp_irq and wake are flops on mclk and cannot rise while mclk is stopped
// - enable bit turns the comparator on, clearing it turns it off
// - synchronized output readable by software, forced zero while disabled
// - one identical control register per comparator, reset value zero
package cmp_irq_pkg;
  localparam int unsigned NUM_CMP = 2;
  localparam int unsigned CTRL_W = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int unsigned BIT_ON = 5;
  localparam int unsigned BIT_POS_SEL = 4;
  localparam int unsigned BIT_NEG_SEL = 3;
  localparam int unsigned BIT_OUT_EN = 2;
  localparam int unsigned BIT_SYNC_OUT = 1;
  localparam int unsigned BIT_FLAG = 0;
  // register addresses, kept for reference by the cpu side
  localparam logic [7:0] CTRL_ADDR_CMP0 = 8'hAC;
  localparam logic [7:0] CTRL_ADDR_CMP1 = 8'hAD;
  localparam int unsigned SETTLE_NS = 10000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: comparator_irq_wake.sv */
// Purpose: change flags, interrupt requests and wake for two comparators
// Assumes: cpu writes control bits through plain ports, one write strobe each
// Notes: an asynchronous catcher records changes while mclk is stopped; the wake output itself is a flop on mclk
`timescale 1ns/1ps
module comparator_irq_wake
  import cmp_irq_pkg::*;
#(
  parameter int unsigned N = cmp_irq_pkg::NUM_CMP
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // analog comparator results, asynchronous
  input wire logic [N-1:0] cmp_raw,
  // control register write port
  input wire logic [N-1:0] ctrl_we,
  input wire logic [cmp_irq_pkg::CTRL_W-1:0] ctrl_wdata,
  // interrupt enables
  input wire logic [N-1:0] cmp_irq_enable,
  input wire logic global_irq_enable,
  // power mode, high while idle or power-down
  input wire logic low_power,
  // control register read back, comparator 0 in low byte
  output logic [N*cmp_irq_pkg::CTRL_W-1:0] cmp_ctrl_reg,
  // analog enables
  output logic [N-1:0] cmp_on,
  // interrupt requests and wake
  output logic [N-1:0] cmp_irq,
  output logic wake
);
  logic [N-1:0] sync1_q;
  logic [N-1:0] sync2_q;
  logic [N-1:0] prev_q;
  logic [N-1:0] cfg_on_q;
  logic [N-1:0] pos_sel_q;
  logic [N-1:0] neg_sel_q;
  logic [N-1:0] out_en_q;
  logic [N-1:0] cmp_change_flag;
  logic [N-1:0] cmp_sync_out;
  logic [N-1:0] toggle;
  logic [N-1:0] async_seen;
  logic [N-1:0] async_seen_s1_q;
  logic [N-1:0] async_seen_s2_q;
  logic [N-1:0] async_seen_s3_q;
  logic [N-1:0] async_set;
  logic [N-1:0] req;
  logic [N-1:0] wake_src;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_cmp
      // two-flop synchroniser on the raw comparator output
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end
        else
        begin
          sync1_q[g] <= cmp_raw[g];
          sync2_q[g] <= sync1_q[g];
        end
      end

      // control bits, written by software
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          cfg_on_q[g] <= CTRL_RESET[BIT_ON];
          pos_sel_q[g] <= CTRL_RESET[BIT_POS_SEL];
          neg_sel_q[g] <= CTRL_RESET[BIT_NEG_SEL];
          out_en_q[g] <= CTRL_RESET[BIT_OUT_EN];
        end
        else if (ctrl_we[g])
        begin
          cfg_on_q[g] <= ctrl_wdata[BIT_ON];
          pos_sel_q[g] <= ctrl_wdata[BIT_POS_SEL];
          neg_sel_q[g] <= ctrl_wdata[BIT_NEG_SEL];
          out_en_q[g] <= ctrl_wdata[BIT_OUT_EN];
        end
      end

      // synchronized output, held at zero while off
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          cmp_sync_out[g] <= 1'b0;
        else
          cmp_sync_out[g] <= cfg_on_q[g] & sync2_q[g];
      end

      // previous sample for change detection
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          prev_q[g] <= 1'b0;
        else
          prev_q[g] <= cmp_sync_out[g];
      end

      assign toggle[g] = cmp_sync_out[g] ^ prev_q[g];

      // the catcher is armed only in low power with the comparator on
      cmp_async_latch u_catch
      (
        .cmp_async(cmp_raw[g]),
        .arm(low_power & cfg_on_q[g]),
        .clr_n(rstn & ~(ctrl_we[g] & ~ctrl_wdata[BIT_FLAG])),
        .seen(async_seen[g])
      );

      // bring the async catch back into mclk before it can touch the flag
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          async_seen_s1_q[g] <= 1'b0;
          async_seen_s2_q[g] <= 1'b0;
          async_seen_s3_q[g] <= 1'b0;
        end
        else
        begin
          async_seen_s1_q[g] <= async_seen[g];
          async_seen_s2_q[g] <= async_seen_s1_q[g];
          async_seen_s3_q[g] <= async_seen_s2_q[g];
        end
      end

      // only the arrival of a catch sets the flag; a level would keep setting it
      // for two cycles after the software clear that also empties the catcher
      assign async_set[g] = async_seen_s2_q[g] & ~async_seen_s3_q[g];

      // sticky flag: set wins over a software write of zero
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          cmp_change_flag[g] <= CTRL_RESET[BIT_FLAG];
        else if (toggle[g] | async_set[g])
          cmp_change_flag[g] <= 1'b1;
        else if (ctrl_we[g] & ~ctrl_wdata[BIT_FLAG])
          cmp_change_flag[g] <= 1'b0;
      end

      assign req[g] = cmp_change_flag[g] & cmp_irq_enable[g] & global_irq_enable;

      // request registered so the port comes from a flop
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          cmp_irq[g] <= 1'b0;
        else
          cmp_irq[g] <= req[g];
      end

      // wake: sync flag path or the raw async catch, both gated by enables
      assign wake_src[g] = (req[g] | async_seen[g]) & cmp_irq_enable[g] & global_irq_enable;

      // read-back image of the control register
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          cmp_ctrl_reg[g*CTRL_W +: CTRL_W] <= CTRL_RESET;
        else
          cmp_ctrl_reg[g*CTRL_W +: CTRL_W] <= {2'b00, cfg_on_q[g], pos_sel_q[g],
            neg_sel_q[g], out_en_q[g], cmp_sync_out[g], cmp_change_flag[g]};
      end

      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          cmp_on[g] <= 1'b0;
        else
          cmp_on[g] <= cfg_on_q[g];
      end

      AST_OFF_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
        !cfg_on_q[g] |=> !cmp_sync_out[g])
        else $error("sync output not zero while comparator off");

      AST_TOGGLE_SETS: assert property (@(posedge mclk) disable iff (!rstn)
        $changed(cmp_sync_out[g]) |=> cmp_change_flag[g])
        else $error("output change did not set flag");

      AST_SET_WINS: assert property (@(posedge mclk) disable iff (!rstn)
        (toggle[g] && ctrl_we[g] && !ctrl_wdata[BIT_FLAG]) |=> cmp_change_flag[g])
        else $error("clear beat a simultaneous set");

      AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (!rstn)
        (cmp_change_flag[g] && !ctrl_we[g]) |=> cmp_change_flag[g])
        else $error("flag dropped without software clear");

      AST_IRQ_GATE: assert property (@(posedge mclk) disable iff (!rstn)
        cmp_irq[g] |-> $past(cmp_change_flag[g] & cmp_irq_enable[g] & global_irq_enable))
        else $error("interrupt without flag and both enables");

      AST_IRQ_RAISE: assert property (@(posedge mclk) disable iff (!rstn)
        (cmp_change_flag[g] && cmp_irq_enable[g] && global_irq_enable) |=> cmp_irq[g])
        else $error("enabled flag did not raise interrupt");

      AST_ENABLE_LOAD: assert property (@(posedge mclk) disable iff (!rstn)
        ctrl_we[g] |=> ##1 (cmp_on[g] == $past(ctrl_wdata[BIT_ON], 2)))
        else $error("enable bit write not reflected on cmp_on");

      AST_LP_FLAG: assert property (@(posedge mclk) disable iff (!rstn)
        (low_power && $changed(cmp_sync_out[g])) |=> cmp_change_flag[g])
        else $error("change in low power not flagged");

      AST_CATCH_SETS: assert property (@(posedge mclk) disable iff (!rstn)
        async_set[g] |=> cmp_change_flag[g])
        else $error("caught change did not set flag");
    end
  endgenerate

  // wake output from a flop; it is also the interrupt in reduced power
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      wake <= 1'b0;
    else
      wake <= low_power & (|wake_src);
  end

  AST_WAKE: assert property (@(posedge mclk) disable iff (!rstn)
    (low_power && |(cmp_change_flag & cmp_irq_enable) && global_irq_enable) |=> wake)
    else $error("enabled change in low power did not wake");
endmodule

/* File: cpu_side_model.sv */
// Purpose: cpu side, merges bench writes with a flag clearing handler
// Assumes: the handler runs only while svc_en is high
// Notes: a holdoff stops a second clear before cmp_irq has fallen
`timescale 1ns/1ps
module cpu_side_model
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // bench requests
  input wire logic svc_en,
  input wire logic [1:0] tb_we,
  input wire logic [7:0] tb_wdata,
  // from the block
  input wire logic [1:0] cmp_irq,
  input wire logic [15:0] cmp_ctrl_reg,
  // to the block
  output logic [1:0] ctrl_we,
  output logic [7:0] ctrl_wdata
);
  logic [2:0] hold_q;
  logic svc;
  // handler clears the flag and keeps the other bits; bench writes win
  assign svc = svc_en && cmp_irq[0] && hold_q == 3'd0 && tb_we == 2'b00;
  assign ctrl_we = svc ? 2'b01 : tb_we;
  assign ctrl_wdata = svc ? (cmp_ctrl_reg[7:0] & 8'h3E) : tb_wdata;
  // the request drops one cycle after the clear lands
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) hold_q <= 3'd0;
    else if (svc) hold_q <= 3'd7;
    else if (hold_q != 3'd0) hold_q <= hold_q - 3'd1;
endmodule

/* File: tb_comparator_irq_wake.sv */
// Purpose: self-checking bench for the comparator event and wake logic
// Assumes: inputs change 1 ns after the rising edge
// Notes: comparator 0 carries the event traffic, comparator 1 sits idle
`timescale 1ns/1ps
module tb_comparator_irq_wake;
  import cmp_irq_pkg::*;
  logic mclk, rstn, svc_en, global_irq_enable, low_power, wake;
  logic [1:0] cmp_raw, tb_we, ctrl_we, cmp_irq_enable, cmp_on, cmp_irq;
  logic [7:0] tb_wdata, ctrl_wdata;
  logic [15:0] cmp_ctrl_reg;
  int fails, n_compared;
  comparator_irq_wake dut (.mclk(mclk), .rstn(rstn), .cmp_raw(cmp_raw),
    .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .cmp_irq_enable(cmp_irq_enable),
    .global_irq_enable(global_irq_enable), .low_power(low_power),
    .cmp_ctrl_reg(cmp_ctrl_reg), .cmp_on(cmp_on), .cmp_irq(cmp_irq), .wake(wake));
  cpu_side_model cpu (.mclk(mclk), .rstn(rstn), .svc_en(svc_en), .tb_we(tb_we),
    .tb_wdata(tb_wdata), .cmp_irq(cmp_irq), .cmp_ctrl_reg(cmp_ctrl_reg),
    .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata));
  // cpu clock, 4 ns period
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // leaves us just after an edge so inputs never race the clock
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [1:0] g, input logic [7:0] d);
    tb_we = g;
    tb_wdata = d;
    tick(1);
    tb_we = 2'b00;
  endtask
  // bounded wait on wake (sel 1) or the comparator 0 request (sel 0)
  task automatic wait_for(input bit sel, input logic v);
    int i;
    for (i = 0; i < 32 && (sel ? wake : cmp_irq[0]) !== v; i++)
      tick(1);
    if (i == 32)
    begin
      chk("wait", {15'd0, v}, {15'd0, ~v});
      tally_and_finish();
    end
  endtask
  task automatic s_enable;
    // out_en is set here; putting that pin in push-pull is software's duty
    wr(2'b11, 8'h3C);
    tick(2);
    chk("cmp_on", 16'h0003, {14'd0, cmp_on});
    chk("readback", 16'h3C3C, cmp_ctrl_reg);
    tick(SETTLE_CYCLES);
  endtask
  task automatic s_poll;
    cmp_raw[0] = 1'b1;
    tick(6);
    chk("flag and out", 16'h3C3F, cmp_ctrl_reg);
    chk("irq off", 16'h0000, {14'd0, cmp_irq});
  endtask
  task automatic s_gate;
    wr(2'b01, 8'h3C);
    tick(2);
    chk("cleared", 16'h003E, {8'd0, cmp_ctrl_reg[7:0]});
    cmp_irq_enable = 2'b01;
    cmp_raw[0] = 1'b0;
    tick(6);
    chk("no global", 16'h0000, {14'd0, cmp_irq});
    global_irq_enable = 1'b1;
    tick(3);
    chk("irq", 16'h0001, {14'd0, cmp_irq});
    svc_en = 1'b1;
    wait_for(1'b0, 1'b0);
    svc_en = 1'b0;
    tick(2);
    chk("served", 16'h003C, {8'd0, cmp_ctrl_reg[7:0]});
  endtask
  task automatic s_wake;
    // power mode goes up a cycle ahead so the catcher is armed before the edge
    low_power = 1'b1;
    tick(1);
    cmp_raw[0] = 1'b1;
    wait_for(1'b1, 1'b1);
    tick(6);
    chk("lp flag", 16'h0001, {15'd0, cmp_ctrl_reg[0]});
    low_power = 1'b0;
    tick(2);
    chk("wake off", 16'h0000, {15'd0, wake});
    svc_en = 1'b1;
    wait_for(1'b0, 1'b0);
    svc_en = 1'b0;
  endtask
  task automatic s_off;
    wr(2'b01, 8'h00);
    tick(1);
    // this clear lands on the edge after switching off toggles the output, where that toggle sets the flag
    wr(2'b01, 8'h00);
    tick(2);
    chk("off", 16'h0000, {14'd0, cmp_on[0], cmp_ctrl_reg[1]});
    chk("set wins", 16'h0001, {15'd0, cmp_ctrl_reg[0]});
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    fails = 0;
    n_compared = 0;
    rstn = 1'b0;
    svc_en = 1'b0;
    global_irq_enable = 1'b0;
    low_power = 1'b0;
    cmp_raw = 2'b00;
    tb_we = 2'b00;
    tb_wdata = 8'h00;
    cmp_irq_enable = 2'b00;
    repeat (12) @(posedge mclk);
    #1 rstn = 1'b1;
    tick(1);
    chk("reset", 16'h0000, cmp_ctrl_reg | {13'd0, cmp_irq, wake});
    s_enable();
    s_poll();
    s_gate();
    s_wake();
    s_off();
    tally_and_finish();
  end
endmodule
